// >>> logic/sar_seq_pkg.sv
// constants and types shared by the converter channel sequencer
package sar_seq_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned CONV_MAX_HZ = 18_000_000;
   localparam int unsigned CONV_DIV = (CLK_HZ + CONV_MAX_HZ - 1) / CONV_MAX_HZ;
   localparam int unsigned CONV_CYCLES = 18;
   localparam int unsigned RES_W = 12;
   localparam int unsigned N_CHAN = 8;
   localparam int unsigned CH_W = 3;
   localparam int unsigned SAMP_W = 8;
   localparam int unsigned DIV_W = 4;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONV_DIV - 1);
   localparam logic [SAMP_W-1:0] CONV_LAST = SAMP_W'(CONV_CYCLES - 1);
   localparam logic [RES_W-1:0] RESULT_RST = 12'h000;
   localparam logic [N_CHAN-1:0] FLAGS_RST = 8'h00;
   localparam logic [CH_W-1:0] CHAN_RST = 3'h0;
   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} seq_state_e;
   typedef logic [N_CHAN-1:0][RES_W-1:0] res_arr_t;
   typedef logic [N_CHAN-1:0][SAMP_W-1:0] samp_arr_t;
endpackage

// >>> logic/sar_limit_check.sv
// window comparator for one converter result
`timescale 1ns/1ns
`default_nettype none
module sar_limit_check (
   input wire logic [11:0] i_value,
   input wire logic [11:0] i_low,
   input wire logic [11:0] i_high,
   output logic o_out_of_range
);
   // strict compare: a value equal to a limit is still in range
   assign o_out_of_range = (i_value < i_low) || (i_value > i_high);
endmodule
`default_nettype wire

// >>> logic/sar_channel_sequencer.sv
// scan sequencer, sample timing, result buffer and limit flags
`timescale 1ns/1ns
`default_nettype none
module sar_channel_sequencer (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_deep_sleep,
   input wire logic i_fw_mode,
   input wire logic i_fw_start,
   input wire logic [sar_seq_pkg::CH_W-1:0] i_fw_chan,
   input wire logic i_scan_start,
   input wire logic i_continuous,
   input wire logic [sar_seq_pkg::N_CHAN-1:0] i_chan_en,
   input wire sar_seq_pkg::samp_arr_t i_samp_time,
   input wire logic [sar_seq_pkg::RES_W-1:0] i_lim_low,
   input wire logic [sar_seq_pkg::RES_W-1:0] i_lim_high,
   input wire logic [sar_seq_pkg::N_CHAN-1:0] i_range_clr,
   input wire logic i_done_clr,
   input wire logic i_done_irq_en,
   input wire logic [sar_seq_pkg::RES_W-1:0] i_result,
   output logic [sar_seq_pkg::CH_W-1:0] o_mux_sel,
   output logic o_sample,
   output logic o_conv_start,
   output logic o_busy,
   output sar_seq_pkg::res_arr_t o_result,
   output logic [sar_seq_pkg::N_CHAN-1:0] o_range_flags,
   output logic o_range_irq,
   output logic o_scan_done,
   output logic o_done_irq
);
   import sar_seq_pkg::*;

   typedef struct packed {
      seq_state_e st;
      logic [DIV_W-1:0] div;
      logic [SAMP_W-1:0] cnt;
      logic [CH_W-1:0] chan;
      logic single;
      logic sample;
      logic conv_start;
      logic busy;
      res_arr_t result;
      logic [N_CHAN-1:0] flags;
      logic range_irq;
      logic done;
      logic done_irq;
   } seq_s;

   seq_s q;
   seq_s d;
   logic conv_en;
   logic capture;
   logic oor;
   logic [CH_W-1:0] nxt;
   logic wrap;

   sar_limit_check u_limit (
      .i_value(i_result),
      .i_low(i_lim_low),
      .i_high(i_lim_high),
      .o_out_of_range(oor)
   );

   // lowest enabled channel after the current one, circularly
   function automatic logic [CH_W-1:0] next_chan(input logic [CH_W-1:0] cur, input logic [N_CHAN-1:0] en);
      logic [CH_W-1:0] r;
      logic [CH_W-1:0] c;
      r = cur;
      for (int i = N_CHAN - 1; i >= 1; i--) begin
         c = cur + CH_W'(i);
         if (en[c]) begin
            r = c;
         end
      end
      return r;
   endfunction

   assign conv_en = (q.div == DIV_LAST);
   assign capture = (q.st == ST_CONVERT) && conv_en && (q.cnt == '0);
   assign nxt = next_chan(q.chan, i_chan_en);
   // a single channel scan also wraps, since nxt equals chan
   assign wrap = q.single || (nxt <= q.chan);

   always_comb begin
      d = q;
      d.conv_start = 1'b0;
      d.div = conv_en ? '0 : q.div + DIV_W'(1);
      // clear first, so a set in the same cycle wins
      d.flags = q.flags & ~i_range_clr;
      d.done = q.done & ~i_done_clr;
      unique case (q.st)
         ST_IDLE: begin
            if (i_fw_mode && i_fw_start) begin
               d.chan = i_fw_chan;
               d.single = 1'b1;
               d.cnt = i_samp_time[i_fw_chan];
               d.st = ST_SAMPLE;
            end else if (!i_fw_mode && i_scan_start && (|i_chan_en)) begin
               d.chan = next_chan(3'h7, i_chan_en);
               d.single = 1'b0;
               d.cnt = i_samp_time[next_chan(3'h7, i_chan_en)];
               d.st = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            if (conv_en) begin
               if (q.cnt == '0) begin
                  d.st = ST_CONVERT;
                  d.cnt = CONV_LAST;
                  d.conv_start = 1'b1;
               end else begin
                  d.cnt = q.cnt - SAMP_W'(1);
               end
            end
         end
         ST_CONVERT: begin
            if (capture) begin
               d.result[q.chan] = i_result;
               if (oor) begin
                  d.flags[q.chan] = 1'b1;
               end
               if (wrap) begin
                  d.done = 1'b1;
               end
               if (q.single || i_fw_mode || (wrap && !i_continuous)) begin
                  d.st = ST_IDLE;
               end else begin
                  // straight into the next sample, no idle cycle between channels
                  d.chan = nxt;
                  d.cnt = i_samp_time[nxt];
                  d.st = ST_SAMPLE;
               end
            end else if (conv_en) begin
               d.cnt = q.cnt - SAMP_W'(1);
            end
         end
      endcase
      if (i_deep_sleep) begin
         // fast clock is about to vanish, abandon any conversion in flight
         d.st = ST_IDLE;
         d.conv_start = 1'b0;
      end
      d.sample = (d.st == ST_SAMPLE);
      d.busy = (d.st != ST_IDLE);
      d.range_irq = |d.flags;
      d.done_irq = d.done && i_done_irq_en;
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         q.st <= ST_IDLE;
         q.div <= '0;
         q.cnt <= '0;
         q.chan <= CHAN_RST;
         q.single <= 1'b0;
         q.sample <= 1'b0;
         q.conv_start <= 1'b0;
         q.busy <= 1'b0;
         q.result <= {N_CHAN{RESULT_RST}};
         q.flags <= FLAGS_RST;
         q.range_irq <= 1'b0;
         q.done <= 1'b0;
         q.done_irq <= 1'b0;
      end else begin
         q <= d;
      end
   end

   assign o_mux_sel = q.chan;
   assign o_sample = q.sample;
   assign o_conv_start = q.conv_start;
   assign o_busy = q.busy;
   assign o_result = q.result;
   assign o_range_flags = q.flags;
   assign o_range_irq = q.range_irq;
   assign o_scan_done = q.done;
   assign o_done_irq = q.done_irq;

   // helper: cycles spent converting before each capture
   logic [7:0] conv_len_q;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         conv_len_q <= '0;
      end else if (q.st == ST_CONVERT) begin
         conv_len_q <= conv_len_q + 8'h01;
      end else begin
         conv_len_q <= '0;
      end
   end

   sequence s_capture_more;
      capture && !i_deep_sleep && !wrap && !q.single && !i_fw_mode;
   endsequence

   AST_CONV_LENGTH: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      capture |-> conv_len_q >= 8'(CONV_CYCLES * CONV_DIV - 1))
      else $error("conversion shorter than its minimum clock count");
   AST_NO_DEAD_CYCLE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      s_capture_more |=> o_sample && o_busy)
      else $error("gap between channels in a scan");
   AST_SCAN_STEP: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      s_capture_more |=> o_mux_sel == $past(nxt) && i_chan_en[o_mux_sel] == $past(i_chan_en[nxt]))
      else $error("scan did not step to the next enabled channel");
   AST_FW_PICK: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (q.st == ST_IDLE && i_fw_mode && i_fw_start && !i_deep_sleep) |=> o_mux_sel == $past(i_fw_chan) ##0 o_sample)
      else $error("firmware channel choice not applied");
   AST_BUFFER: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (capture && !i_deep_sleep) |=> o_result[$past(q.chan)] == $past(i_result))
      else $error("result not stored in its channel entry");
   AST_SAMPLE_FIRST: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $rose(o_conv_start) |-> $past(o_sample) && !o_sample)
      else $error("conversion started without a sample phase");
   AST_RANGE_IRQ: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (capture && oor && !i_deep_sleep) |=> o_range_flags[$past(q.chan)] ##1 o_range_irq)
      else $error("out of range result did not raise the interrupt");
   AST_SLEEP_STOP: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_deep_sleep |=> !o_busy && !o_sample && !o_conv_start)
      else $error("converter active in deep sleep");
   AST_SCAN_DONE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (capture && wrap && !i_deep_sleep) |=> o_scan_done ##1 (o_done_irq == $past(i_done_irq_en)))
      else $error("scan completion not flagged");
endmodule
`default_nettype wire

// >>> tb/sar_core_model.sv
// behavioural converter core and input multiplexer
`timescale 1ns/1ns
`default_nettype none
module sar_core_model (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [2:0] i_sel,
   input wire logic i_conv_start,
   input wire sar_seq_pkg::res_arr_t i_level,
   output logic [11:0] o_result
);
   import sar_seq_pkg::*;
   logic [4:0] cnt_q;
   logic [11:0] val_q;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_q <= 5'h00;
         val_q <= 12'h000;
      end else if (i_conv_start) begin
         cnt_q <= 5'h12;
         val_q <= i_level[i_sel];
      end else if (cnt_q != 5'h00) begin
         cnt_q <= cnt_q - 5'h01;
      end
   end
   // outside the window the line shows junk, never a stale match
   assign o_result = (cnt_q != 5'h00) ? val_q : ~val_q;
endmodule
`default_nettype wire

// >>> tb/sar_channel_sequencer_tb.sv
// bench for the converter channel sequencer
`timescale 1ns/1ns
`default_nettype none
module sar_channel_sequencer_tb;
   import sar_seq_pkg::*;
   logic clk = 0, rst_n = 0, sleep = 0, fw = 0, fw_go = 0, go = 0, cont = 0, dclr = 0, den = 0;
   logic [2:0] fw_ch = 3'h0, sel;
   logic [7:0] en = 8'h00, rclr = 8'h00, flags;
   samp_arr_t samp = '0;
   res_arr_t lvl = '0, res;
   logic [11:0] core_res;
   logic [11:0] lim_lo = 12'h100, lim_hi = 12'h800;
   logic smp, cst, busy, rirq, done, dirq;
   int bad_count = 0, n_tests = 0, k;
   always #50 clk = ~clk;
   sar_core_model core_u (.i_clk(clk), .i_reset_n(rst_n), .i_sel(sel), .i_conv_start(cst), .i_level(lvl),
      .o_result(core_res));
   sar_channel_sequencer dut_u (.i_clk(clk), .i_reset_n(rst_n), .i_deep_sleep(sleep), .i_fw_mode(fw),
      .i_fw_start(fw_go), .i_fw_chan(fw_ch), .i_scan_start(go), .i_continuous(cont), .i_chan_en(en),
      .i_samp_time(samp), .i_lim_low(lim_lo), .i_lim_high(lim_hi), .i_range_clr(rclr), .i_done_clr(dclr),
      .i_done_irq_en(den), .i_result(core_res), .o_mux_sel(sel), .o_sample(smp), .o_conv_start(cst),
      .o_busy(busy), .o_result(res), .o_range_flags(flags), .o_range_irq(rirq), .o_scan_done(done),
      .o_done_irq(dirq));
   task automatic cmp(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // pulse a start and count cycles until done rises
   task automatic scan(output int n);
      @(negedge clk) go = 1;
      n = 0;
      do begin
         @(negedge clk);
         go = 0;
         n++;
      end while (!done && n < 2000);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      bad_count++;
      conclude();
   end
   initial begin
      lvl[0] = 12'h100;
      lvl[2] = 12'hf00;
      lvl[5] = 12'h7ff;
      lvl[7] = 12'h0ff;
      repeat (4) @(negedge clk);
      rst_n = 1;
      cmp("busy", busy, 0);
      cmp("flags", flags, 0);
      en = 8'h05;
      samp[2] = 8'h03;
      den = 1;
      scan(k);
      // start cycle, then per channel (sample ticks + 1) plus the conversion
      cmp("cycles", k, 1 + (0 + 1) + CONV_CYCLES + (3 + 1) + CONV_CYCLES);
      cmp("res0", res[0], 12'h100);
      cmp("res2", res[2], 12'hf00);
      cmp("flags", flags, 8'h04);
      cmp("busy", busy, 0);
      @(negedge clk);
      cmp("rirq", rirq, 1);
      cmp("dirq", dirq, 1);
      rclr = 8'hff;
      dclr = 1;
      @(negedge clk);
      rclr = 8'h00;
      dclr = 0;
      @(negedge clk);
      cmp("flags", flags, 0);
      cmp("done", done, 0);
      cmp("rirq", rirq, 0);
      cmp("dirq", dirq, 0);
      en = 8'h80;
      cont = 1;
      scan(k);
      cmp("cycles", k, 1 + (0 + 1) + CONV_CYCLES);
      cmp("res7", res[7], 12'h0ff);
      // new level before the next conversion start is latched by the core
      lvl[7] = 12'h0a5;
      repeat (2) @(negedge clk);
      cmp("busy", busy, 1);
      cont = 0;
      k = 0;
      while (busy && k < 100) begin
         @(negedge clk);
         k++;
      end
      cmp("idle", busy, 0);
      cmp("res7", res[7], 12'h0a5);
      fw = 1;
      fw_ch = 3'h5;
      den = 0;
      lim_hi = 12'h7fe;
      @(negedge clk) fw_go = 1;
      @(negedge clk) fw_go = 0;
      cmp("sel", sel, 3'h5);
      cmp("smp", smp, 1);
      k = 0;
      while (busy && k < 100) begin
         @(negedge clk);
         k++;
      end
      cmp("idle", busy, 0);
      cmp("res5", res[5], 12'h7ff);
      cmp("flags", flags, 8'ha0);
      cmp("done", done, 1);
      cmp("dirq", dirq, 0);
      fw = 0;
      // sleep in mid conversion must abandon it
      @(negedge clk) go = 1;
      @(negedge clk) go = 0;
      repeat (3) @(negedge clk);
      cmp("busy", busy, 1);
      sleep = 1;
      @(negedge clk);
      cmp("busy", busy, 0);
      sleep = 1;
      @(negedge clk) go = 1;
      @(negedge clk) go = 0;
      @(negedge clk);
      cmp("busy", busy, 0);
      cmp("res7", res[7], 12'h0a5);
      conclude();
   end
endmodule
`default_nettype wire
